// file: design/cace_exec.sv
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Function
// - add to memory: memory byte gets working register plus byte, w kept
// - add to w: working register gets sum, memory byte kept
// - add literal: byte constant added to w, result into w
// - sum above 0xFF sets carry, low eight bits kept; else carry cleared
// - carry out of bit 3 into bit 4 sets digit carry, else cleared
// - zero eight-bit result sets zero flag, including sum 0x100
// - add with carry to memory: w plus carry plus byte into memory
// - add with carry to w: byte plus w plus carry into w
// - add to memory takes one cycle, three when target is pc low byte
// - and into memory: byte and w stored in memory, zero sets flag
// - and into w: w and byte into w, memory kept
// - pattern 1110 ands w with byte constant, zero sets flag
// - and clears zero flag on nonzero result, carries untouched
// - debug halt flushes, stops, runs nops, flags untouched
// - halt left only by reset or debug interface command
// - call pushes next address, takes three cycles, flags kept
// - call target: constant gives bits 12:0, page bits give 15:13
// - return pops saved address into the program counter
// - clear writes zero to memory byte, sets zero flag, one cycle, three when target is pc low byte
module cace_exec
  import cace_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        ARST_N,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             HALTED,
  output logic             BUSY
);

  function automatic cace_op_t decode_op(input logic [15:0] ins);
    cace_op_t op;
    op = OP_NOP;
    if ((ins & MASK_F) == OPC_ADD_FW) op = OP_ADD_FW;
    else if ((ins & MASK_F) == OPC_ADD_WF) op = OP_ADD_WF;
    else if ((ins & MASK_L8) == OPC_ADD_WL) op = OP_ADD_WL;
    else if ((ins & MASK_F) == OPC_ADDC_FW) op = OP_ADDC_FW;
    else if ((ins & MASK_F) == OPC_ADDC_WF) op = OP_ADDC_WF;
    else if ((ins & MASK_F) == OPC_AND_FW) op = OP_AND_FW;
    else if ((ins & MASK_F) == OPC_AND_WF) op = OP_AND_WF;
    else if ((ins & MASK_L12) == OPC_AND_WL) op = OP_AND_WL;
    else if ((ins & MASK_L13) == OPC_CALL) op = OP_CALL;
    else if ((ins & MASK_F) == OPC_CLR) op = OP_CLR;
    else if (ins == OPC_BREAK) op = OP_BREAK;
    else if (ins == OPC_RET) op = OP_RET;
    return op;
  endfunction : decode_op
  function automatic cace_alu_t add8(input logic [7:0] a,
                                     input logic [7:0] b,
                                     input logic       cin);
    cace_alu_t  r;
    logic [8:0] full;
    logic [4:0] low;
    full  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    r.res = full[7:0];
    r.c   = full[8];
    r.dgt = low[4];
    r.z   = (full[7:0] == 8'h00);
    return r;
  endfunction : add8
  function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [7:0] nw,
                                        input logic       en);
    return en ? nw : old;
  endfunction : merge8
  // bus state
  logic        awready_reg, wready_reg, aw_have_reg, w_have_reg;
  logic        bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0]  wstrb_reg;
  // core state
  logic [7:0]  w_reg, status_reg;
  logic [15:0] pc_reg;
  logic [7:0]  dmem_reg [DMEM_DEPTH];
  logic [15:0] stack_reg [STACK_DEPTH];
  logic [DMEM_IW-1:0] midx_reg;
  logic        halted_reg, busy_reg, drop_reg;
  logic [1:0]  busy_cnt_reg;
  // execution datapath
  logic        wr_fire, wr_ok, instr_wr, exec_go, to_pc_low;
  logic        mem_we, push, pop, halt_set;
  logic [15:0] instr, pc_next;
  cace_op_t    op;
  logic [8:0]  f_addr;
  logic [7:0]  k_byte, fval, w_next, status_next, mem_wd;
  cace_alu_t   alu;
  logic [1:0]  extra;
  assign wr_fire  = aw_have_reg & w_have_reg;
  assign wr_ok    = (awaddr_reg <= REG_TOS) && (awaddr_reg[1:0] == 2'b00);
  assign instr_wr = wr_fire && (awaddr_reg == REG_INSTR)
                    && (wstrb_reg[1:0] == 2'b11);
  // a word written while a multi-cycle op runs or while halted is not run
  assign exec_go  = instr_wr && !busy_reg && !halted_reg;
  assign instr    = wdata_reg[15:0];
  assign op       = decode_op(instr);
  assign f_addr   = instr[8:0];
  assign k_byte   = instr[7:0];
  assign to_pc_low = (f_addr == PC_LOW_ADDR);
  // the pc low byte aliases a memory address, as operand and as target
  assign fval     = to_pc_low ? pc_reg[7:0] : dmem_reg[f_addr[DMEM_IW-1:0]];

  always_comb begin
    alu         = add8(w_reg, fval, 1'b0);
    w_next      = w_reg;
    status_next = status_reg;
    pc_next     = pc_reg;
    mem_we      = 1'b0;
    mem_wd      = 8'h00;
    push        = 1'b0;
    pop         = 1'b0;
    extra       = EXTRA_NONE;
    halt_set    = 1'b0;
    if (exec_go) begin
      pc_next = pc_reg + 16'h0001;
      case (op)
        OP_ADD_FW, OP_ADDC_FW: begin
          alu    = add8(w_reg, fval, (op == OP_ADDC_FW) &&
                        status_reg[STAT_C]);
          mem_we = 1'b1;
          mem_wd = alu.res;
        end
        OP_ADD_WF, OP_ADDC_WF: begin
          alu    = add8(w_reg, fval, (op == OP_ADDC_WF) &&
                        status_reg[STAT_C]);
          w_next = alu.res;
        end
        OP_ADD_WL: begin
          alu    = add8(w_reg, k_byte, 1'b0);
          w_next = alu.res;
        end
        OP_AND_FW: begin
          alu.res = w_reg & fval;
          mem_we  = 1'b1;
          mem_wd  = alu.res;
        end
        OP_AND_WF: begin
          alu.res = w_reg & fval;
          w_next  = alu.res;
        end
        OP_AND_WL: begin
          alu.res = w_reg & k_byte;
          w_next  = alu.res;
        end
        OP_CLR: begin
          alu.res = 8'h00;
          mem_we  = 1'b1;
          mem_wd  = 8'h00;
        end
        OP_CALL: begin
          push    = 1'b1;
          pc_next = {status_reg[STAT_PAGE +: 3], instr[12:0]};
          extra   = EXTRA_CALL;
        end
        OP_RET: begin
          pop     = 1'b1;
          pc_next = stack_reg[0];
        end
        OP_BREAK: begin
          // the advance is cancelled so the pc names the halt word
          pc_next  = pc_reg;
          halt_set = 1'b1;
        end
        default: ;
      endcase
      case (op)
        OP_ADD_FW, OP_ADD_WF, OP_ADD_WL, OP_ADDC_FW, OP_ADDC_WF: begin
          status_next[STAT_C]  = alu.c;
          status_next[STAT_DIG] = alu.dgt;
          status_next[STAT_Z]  = alu.z;
        end
        OP_AND_FW, OP_AND_WF, OP_AND_WL: begin
          status_next[STAT_Z]  = (alu.res == 8'h00);
        end
        OP_CLR: begin
          status_next[STAT_Z]  = 1'b1;
        end
        default: ;
      endcase
      // a memory write aimed at the pc low byte is a computed jump
      if (mem_we && to_pc_low) begin
        mem_we  = 1'b0;
        pc_next = {pc_reg[15:8], mem_wd};
        extra   = EXTRA_JUMP;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      w_reg <= WORK_RST;
    end else if (exec_go) begin
      w_reg <= w_next;
    end else if (wr_fire && awaddr_reg == REG_WORK) begin
      w_reg <= merge8(w_reg, wdata_reg[7:0], wstrb_reg[0]);
    end
  end
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      status_reg <= STATUS_RST;
    end else if (exec_go) begin
      status_reg <= status_next;
    end else if (wr_fire && awaddr_reg == REG_STATUS) begin
      status_reg <= merge8(status_reg, wdata_reg[7:0], wstrb_reg[0]);
    end
  end
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pc_reg <= PC_RST;
    end else if (exec_go) begin
      pc_reg <= pc_next;
    end else if (wr_fire && awaddr_reg == REG_PC) begin
      pc_reg <= {merge8(pc_reg[15:8], wdata_reg[15:8], wstrb_reg[1]),
                 merge8(pc_reg[7:0], wdata_reg[7:0], wstrb_reg[0])};
    end
  end
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      midx_reg <= '0;
    end else if (wr_fire && awaddr_reg == REG_MIDX && wstrb_reg[0]) begin
      midx_reg <= wdata_reg[DMEM_IW-1:0];
    end
  end
  // only the low address bits index the store, so upper addresses alias
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < DMEM_DEPTH; i++) begin
        dmem_reg[i] <= 8'h00;
      end
    end else if (mem_we) begin
      dmem_reg[f_addr[DMEM_IW-1:0]] <= mem_wd;
    end else if (wr_fire && awaddr_reg == REG_MDATA && wstrb_reg[0]) begin
      dmem_reg[midx_reg] <= wdata_reg[7:0];
    end
  end

  // shift stack: a push past the depth loses the oldest entry
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_reg[i] <= 16'h0000;
      end
    end else if (push) begin
      stack_reg[0] <= pc_reg + 16'h0001;
      for (int i = 1; i < STACK_DEPTH; i++) begin
        stack_reg[i] <= stack_reg[i-1];
      end
    end else if (pop) begin
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        stack_reg[i] <= stack_reg[i+1];
      end
      stack_reg[STACK_DEPTH-1] <= 16'h0000;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      halted_reg <= 1'b0;
    end else if (halt_set) begin
      halted_reg <= 1'b1;
    end else if (wr_fire && awaddr_reg == REG_DEBUG && wstrb_reg[0]
                 && wdata_reg[0]) begin
      halted_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      busy_cnt_reg <= 2'h0;
      busy_reg     <= 1'b0;
    end else if (exec_go) begin
      busy_cnt_reg <= extra;
      busy_reg     <= (extra != 2'h0);
    end else if (busy_cnt_reg != 2'h0) begin
      busy_cnt_reg <= busy_cnt_reg - 2'h1;
      busy_reg     <= (busy_cnt_reg != 2'h1);
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      drop_reg <= 1'b0;
    end else if (instr_wr && !exec_go) begin
      drop_reg <= 1'b1;
    end else if (wr_fire && awaddr_reg == REG_STATE && wstrb_reg[0]
                 && wdata_reg[STATE_DROP]) begin
      drop_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && awready_reg) begin
        awready_reg <= 1'b0;
        aw_have_reg <= 1'b1;
        awaddr_reg  <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && wready_reg) begin
        wready_reg <= 1'b0;
        w_have_reg <= 1'b1;
        wdata_reg  <= S_AXI_WDATA;
        wstrb_reg  <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_reg && S_AXI_BREADY) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  function automatic logic [31:0] read_mux(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      REG_WORK:   d[7:0] = w_reg;
      REG_STATUS: d[7:0] = status_reg;
      REG_PC:     d[15:0] = pc_reg;
      REG_MIDX:   d[DMEM_IW-1:0] = midx_reg;
      REG_MDATA:  d[7:0] = dmem_reg[midx_reg];
      REG_STATE:  d[2:0] = {drop_reg, busy_reg, halted_reg};
      REG_TOS:    d[15:0] = stack_reg[0];
      default:    d = 32'h0000_0000;
    endcase
    return d;
  endfunction : read_mux

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else if (S_AXI_ARVALID && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= read_mux(S_AXI_ARADDR);
      rresp_reg   <= (S_AXI_ARADDR <= REG_TOS &&
                      S_AXI_ARADDR[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign S_AXI_AWREADY = awready_reg;
  assign S_AXI_WREADY  = wready_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_ARREADY = arready_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;
  assign HALTED        = halted_reg;
  assign BUSY          = busy_reg;

endmodule : cace_exec

// file: design/cace_pkg.sv
package cace_pkg;

  // register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] REG_INSTR  = 8'h00;
  localparam logic [7:0] REG_WORK   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PC     = 8'h0C;
  localparam logic [7:0] REG_MIDX   = 8'h10;
  localparam logic [7:0] REG_MDATA  = 8'h14;
  localparam logic [7:0] REG_STATE  = 8'h18;
  localparam logic [7:0] REG_DEBUG  = 8'h1C;
  localparam logic [7:0] REG_TOS    = 8'h20;

  // status register layout
  localparam int unsigned STAT_C    = 0;
  localparam int unsigned STAT_DIG  = 1;
  localparam int unsigned STAT_Z    = 2;
  localparam int unsigned STAT_PAGE = 5;

  // state register layout
  localparam int unsigned STATE_HALT = 0;
  localparam int unsigned STATE_BUSY = 1;
  localparam int unsigned STATE_DROP = 2;

  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [7:0]  WORK_RST   = 8'h00;
  localparam logic [15:0] PC_RST     = 16'h0000;

  // opcode values and the masks of their fixed bits
  localparam logic [15:0] MASK_F     = 16'hFE00;
  localparam logic [15:0] MASK_L8    = 16'hFF00;
  localparam logic [15:0] MASK_L12   = 16'hF000;
  localparam logic [15:0] MASK_L13   = 16'hE000;
  localparam logic [15:0] OPC_ADD_FW  = 16'h1E00;
  localparam logic [15:0] OPC_ADD_WF  = 16'h1C00;
  localparam logic [15:0] OPC_ADD_WL  = 16'h7B00;
  localparam logic [15:0] OPC_ADDC_FW = 16'h5E00;
  localparam logic [15:0] OPC_ADDC_WF = 16'h5C00;
  localparam logic [15:0] OPC_AND_FW  = 16'h1600;
  localparam logic [15:0] OPC_AND_WF  = 16'h1400;
  localparam logic [15:0] OPC_AND_WL  = 16'hE000;
  localparam logic [15:0] OPC_CALL    = 16'hC000;
  localparam logic [15:0] OPC_CLR     = 16'h0600;
  localparam logic [15:0] OPC_BREAK   = 16'h0001;
  localparam logic [15:0] OPC_RET     = 16'h0007;

  localparam logic [8:0]  PC_LOW_ADDR = 9'h009;
  localparam int unsigned DMEM_DEPTH  = 32;
  localparam int unsigned DMEM_IW     = 5;
  localparam int unsigned STACK_DEPTH = 4;

  // extra cycles beyond the first
  localparam logic [1:0]  EXTRA_JUMP  = 2'h2;
  localparam logic [1:0]  EXTRA_CALL  = 2'h2;
  localparam logic [1:0]  EXTRA_NONE  = 2'h0;

  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    OP_NOP     = 4'b0000,
    OP_ADD_FW  = 4'b0001,
    OP_ADD_WF  = 4'b0010,
    OP_ADD_WL  = 4'b0011,
    OP_ADDC_FW = 4'b0100,
    OP_ADDC_WF = 4'b0101,
    OP_AND_FW  = 4'b0110,
    OP_AND_WF  = 4'b0111,
    OP_AND_WL  = 4'b1000,
    OP_CALL    = 4'b1001,
    OP_CLR     = 4'b1010,
    OP_BREAK   = 4'b1011,
    OP_RET     = 4'b1100
  } cace_op_t;

  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       dgt;
    logic       z;
  } cace_alu_t;

endpackage : cace_pkg

// file: tb/cace_exec_props.sv
`timescale 1ns/10ps
module cace_exec_props
  import cace_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        ARST_N,
  input wire logic [7:0]  S_AXI_AWADDR,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        HALTED,
  input wire logic        BUSY
);
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!ARST_N);

  logic [7:0]  aw_reg;
  logic [15:0] wd_reg;

  // last taken address and word, so a commit can be tied to its cause
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_reg <= 8'h00;
      wd_reg <= 16'h0000;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
        aw_reg <= S_AXI_AWADDR;
      if (S_AXI_WVALID && S_AXI_WREADY)
        wd_reg <= S_AXI_WDATA[15:0];
    end
  end

  sequence commit_s(logic [7:0] a);
    $rose(S_AXI_BVALID) && aw_reg == a;
  endsequence
  sequence both_take_s;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence

  busy_cause_a: assert property ($rose(BUSY) |-> commit_s(REG_INSTR))
    else $error("busy rose without an instruction commit");
  busy_len_a: assert property ($rose(BUSY) |=> BUSY ##1 !BUSY)
    else $error("busy not two cycles long");
  halt_entry_a: assert property (
    $rose(HALTED) |-> commit_s(REG_INSTR) ##0 wd_reg == OPC_BREAK)
    else $error("halt entered without a halt instruction");
  halt_exit_a: assert property (
    $fell(HALTED) |-> commit_s(REG_DEBUG))
    else $error("halt left without a resume command");
  halt_quiet_a: assert property (HALTED |-> !BUSY)
    else $error("busy while halted");
  wr_answer_a: assert property (
    both_take_s |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
    else $error("write answer off time");
  rd_answer_a: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer off time");
  rd_error_a: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h20 |=>
    S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0000_0000)
    else $error("unmapped read not refused");
  b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
endmodule : cace_exec_props

bind cace_exec cace_exec_props u_props (
  .REF_CLK, .ARST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
  .S_AXI_WDATA, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
  .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
  .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
  .HALTED, .BUSY
);

// file: tb/cace_pmem.sv
`timescale 1ns/10ps
module cace_pmem
  import cace_pkg::*;
(
  input  wire logic [15:0] fetch_addr,
  output logic      [15:0] fetch_word
);
  // small program store: call, return, then stop for the debugger
  always_comb begin
    case (fetch_addr)
      16'h0000: fetch_word = OPC_CALL | 16'h1ABC;
      16'hBABC: fetch_word = OPC_RET;
      16'h0001: fetch_word = OPC_BREAK;
      default:  fetch_word = 16'h0000;
    endcase
  end
endmodule : cace_pmem

// file: tb/cace_exec_tb.sv
`timescale 1ns/10ps
module cace_exec_tb
  import cace_pkg::*;
;
  logic        ref_clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, halted, busy;
  logic [7:0]  awaddr, araddr, w, m, res, st;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, bq[$];
  logic [33:0] rq[$], re;
  logic [15:0] lfsr, exp_pc, pm_addr, pm_word, opc[9];
  logic [8:0]  s9;
  logic [4:0]  idx, h5;
  logic        c, dcx, z, cin, md;
  int          err_count = 0, n_tests = 0, k, j;

  cace_exec DUT (
    .REF_CLK(ref_clk), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .HALTED(halted),
    .BUSY(busy)
  );
  cace_pmem u_pmem (.fetch_addr(pm_addr), .fetch_word(pm_word));

  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt

  task automatic results();
    $display("mismatches %0d, checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  task automatic cmp_data(input string nm, input logic [31:0] e, s);
    n_tests++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, s);
      err_count++;
    end
  endtask : cmp_data

  task automatic cmp_resp(input string nm, input logic [1:0] e, s);
    n_tests++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, s);
      err_count++;
    end
  endtask : cmp_resp

  task automatic tmo();
    cmp_data("wait", 32'h0000_0000, 32'h0000_0001);
    results();
  endtask : tmo

  // write and address travel together; the answer is awaited, not timed
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    bq.push_back(r);
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    bready <= 1'b0;
    if (n == 50)
      tmo();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    rq.push_back({d, r});
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    rready <= 1'b0;
    if (n == 50)
      tmo();
  endtask : rd

  task automatic wr8(input logic [7:0] a, input logic [7:0] v);
    wr(a, {24'h00_0000, v}, RESP_OKAY);
  endtask : wr8

  task automatic rd8(input logic [7:0] a, input logic [7:0] v);
    rd(a, {24'h00_0000, v}, RESP_OKAY);
  endtask : rd8

  task automatic idle();
    int n;
    for (n = 0; n < 50 && busy !== 1'b0; n++)
      @(posedge ref_clk);
    if (n == 50)
      tmo();
  endtask : idle

  // fetch from the program store at the expected pc and execute it
  task automatic run(input logic [15:0] nxt_pc);
    pm_addr = exp_pc;
    #1;
    wr(REG_INSTR, {16'h0000, pm_word}, RESP_OKAY);
    idle();
    exp_pc = nxt_pc;
    rd(REG_PC, {16'h0000, exp_pc}, RESP_OKAY);
  endtask : run

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (rvalid && rready) begin
      re = rq.pop_front();
      cmp_data("rdata", re[33:2], rdata);
      cmp_resp("rresp", re[1:0], rresp);
    end
    if (bvalid && bready)
      cmp_resp("bresp", bq.pop_front(), bresp);
  end

  initial begin
    {arst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0000_0000_0000;
    wstrb = 4'hF;
    {exp_pc, pm_addr} = 32'h0000_0000;
    lfsr = 16'h142A;
    opc = '{OPC_ADD_FW, OPC_ADD_WF, OPC_ADD_WL, OPC_ADDC_FW, OPC_ADDC_WF,
            OPC_AND_FW, OPC_AND_WF, OPC_AND_WL, OPC_CLR};
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(REG_PC, 32'h0000_0000, RESP_OKAY);
    wr8(REG_STATUS, 8'hA0);
    run(16'hBABC);
    rd8(REG_TOS, 8'h01);
    rd8(REG_STATUS, 8'hA0);
    run(16'h0001);
    run(16'h0001);
    cmp_data("halted", 32'h0000_0001, {31'h0, halted});
    wr(REG_INSTR, {16'h0000, OPC_ADD_WL | 16'h0055}, RESP_OKAY);
    rd8(REG_STATE, 8'h05);
    rd8(REG_WORK, 8'h00);
    rd8(REG_STATUS, 8'hA0);
    wr8(REG_DEBUG, 8'h01);
    wr8(REG_STATE, 8'h04);
    rd8(REG_STATE, 8'h00);
    // every add, and and clear opcode, first with w 0x88 and byte 0x78, which sum to 0x100 before carry in
    for (k = 0; k < 9; k++) begin
      for (j = 0; j < 4; j++) begin
        lfsr = nxt(lfsr);
        w = (j == 0) ? 8'h88 : lfsr[7:0];
        lfsr = nxt(lfsr);
        m = (j == 0) ? 8'h78 : lfsr[7:0];
        st = {5'h00, lfsr[10:8]};
        idx = lfsr[15:11];
        wr8(REG_MIDX, {3'h0, idx});
        wr8(REG_MDATA, m);
        wr8(REG_WORK, w);
        wr8(REG_STATUS, st);
        cin = (k == 3 || k == 4) ? st[0] : 1'b0;
        s9 = {1'b0, w} + {1'b0, m} + {8'h00, cin};
        h5 = {1'b0, w[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
        res = (k < 5) ? s9[7:0] : ((k == 8) ? 8'h00 : (w & m));
        c = (k < 5) ? s9[8] : st[0];
        dcx = (k < 5) ? h5[4] : st[1];
        z = (res == 8'h00);
        md = (k == 0 || k == 3 || k == 5 || k == 8);
        if (k == 2 || k == 7)
          wr(REG_INSTR, {16'h0000, opc[k] | {8'h00, m}}, RESP_OKAY);
        else
          wr(REG_INSTR, {16'h0000, opc[k] | {7'h00, 4'h1, idx}}, RESP_OKAY);
        exp_pc = exp_pc + 16'h0001;
        rd8(REG_WORK, md ? w : res);
        rd8(REG_MDATA, md ? res : m);
        rd8(REG_STATUS, {5'h00, z, dcx, c});
        rd(REG_PC, {16'h0000, exp_pc}, RESP_OKAY);
      end
    end
    wr(REG_PC, 32'h0000_1230, RESP_OKAY);
    wr8(REG_WORK, 8'h04);
    wr(REG_INSTR, {16'h0000, OPC_ADD_FW | 16'h0009}, RESP_OKAY);
    cmp_data("busy", 32'h0000_0001, {31'h0, busy});
    idle();
    rd(REG_PC, 32'h0000_1234, RESP_OKAY);
    wstrb <= 4'h2;
    wr(REG_PC, 32'h0000_56FF, RESP_OKAY);
    wstrb <= 4'hF;
    rd(REG_PC, 32'h0000_5634, RESP_OKAY);
    rd(8'h24, 32'h0000_0000, RESP_SLVERR);
    wr(8'h06, 32'h0000_00FF, RESP_SLVERR);
    results();
  end
endmodule : cace_exec_tb
